/* inc/iohsd_defs.vh */
// constants for the io head start-up and diagnosis policy block
`ifndef IOHSD_DEFS_VH
`define IOHSD_DEFS_VH

// register word addresses
`define IOHSD_REG_CTRL     4'h0
`define IOHSD_REG_STATUS   4'h1
`define IOHSD_REG_IRQ_STAT 4'h2
`define IOHSD_REG_IRQ_MASK 4'h3
`define IOHSD_REG_DPV1     4'h4

// control register fields
`define IOHSD_CTRL_HOT_SWAP   0
`define IOHSD_CTRL_START_CONS 1
`define IOHSD_CTRL_OUT_DIS_EN 2
`define IOHSD_CTRL_DIAG_STAT  3
`define IOHSD_CTRL_REDUNDANT  4
`define IOHSD_CTRL_WIDTH      5
`define IOHSD_CTRL_RESET      5'h00

// extended acyclic configuration fields
`define IOHSD_DPV1_ENABLE     0
`define IOHSD_DPV1_ALARM_LSB  1
`define IOHSD_DPV1_ALARM_MSB  7
`define IOHSD_DPV1_WIDTH      8
`define IOHSD_DPV1_RESET      8'h00

// interrupt event bits
`define IOHSD_IRQ_ERROR     0
`define IOHSD_IRQ_DIAG      1
`define IOHSD_IRQ_STARTUP   2
`define IOHSD_IRQ_INHIBIT   3
`define IOHSD_IRQ_WIDTH     4
`define IOHSD_IRQ_RESET     4'h0

// policy states
`define IOHSD_ST_OFFLINE 2'h0
`define IOHSD_ST_STARTUP 2'h1
`define IOHSD_ST_RUN     2'h2
`define IOHSD_ST_ERROR   2'h3

`endif

/* src/iohsd_policy.v */
// start-up consistency, error state, output inhibit and diagnosis policy of the io head
`timescale 1ns/1ns
`include "iohsd_defs.vh"

// How it works
// [R1] start-up is first on-line or primary entry
// [R2] hot swap off: any module fault errors
// [R3] start-up consistency: faults at start-up error
// [R4] start-up consistency: later faults only diagnose
// [R5] power interruption restarts; missing module errors
// [R6] redundant pair: changeover never reruns test
// [R7] no consistency: faults only produce diagnosis
// [R8] output inhibit obeyed only when enabled
// [R9] status reporting off: module changes only
// [R10] status reporting on: module or system changes
// [R11] alarm and slave-function settings are ignored
// [R12] class 2 acyclic accepted without class 1
// [R13] cyclic-only master unaffected by acyclic enable
// [R14] master disables redundant-only parameters
// [R15] master sets channel length 4 to 244
// [R16] error persists until next start-up
module iohsd_policy #(
	parameter NUM_MODULES = 8
) (
	input wire ref_clk_in,
	input wire rstn_in,
	// avalon-mm slave
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	output wire [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	// head state pins
	input wire power_good_in,
	input wire online_in,
	input wire primary_online_in,
	input wire redundancy_changeover_request_in,
	input wire [NUM_MODULES-1:0] module_fault_in,
	input wire [NUM_MODULES-1:0] module_missing_in,
	input wire [7:0] system_status_in,
	input wire inhibit_cmd_in,
	input wire class1_acyc_req_in,
	input wire class2_acyc_req_in,
	// results
	output wire cyclic_outputs_enable_out,
	output wire outputs_inhibit_out,
	output wire error_state_out,
	output wire diag_pulse_out,
	output wire class1_acyc_accept_out,
	output wire class2_acyc_accept_out,
	output wire irq_out
);
	localparam NPIN = 2 * NUM_MODULES + 14;

	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	// all pins share one delay, so their relative order of change is kept
	wire [NPIN-1:0] pins_raw;
	wire [NPIN-1:0] pins_s;
	assign pins_raw = {power_good_in, online_in, primary_online_in, redundancy_changeover_request_in,
		inhibit_cmd_in, class1_acyc_req_in, class2_acyc_req_in, system_status_in[6:0],
		module_fault_in, module_missing_in};

	iohsd_sync #(
		.WIDTH(NPIN)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// top status bit has its own pair of flops, same two-cycle delay as the rest
	reg sys7_m_q;
	reg sys7_q;
	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sys7_m_q <= 1'b0;
			sys7_q <= 1'b0;
		end else begin
			sys7_m_q <= system_status_in[7];
			sys7_q <= sys7_m_q;
		end
	end

	wire pwr_s = pins_s[NPIN-1];
	wire online_s = pins_s[NPIN-2];
	wire primary_s = pins_s[NPIN-3];
	wire changeover_s = pins_s[NPIN-4];
	wire inhibit_s = pins_s[NPIN-5];
	wire c1_s = pins_s[NPIN-6];
	wire c2_s = pins_s[NPIN-7];
	wire [7:0] sys_s = {sys7_q, pins_s[2*NUM_MODULES+6:2*NUM_MODULES]};
	wire [NUM_MODULES-1:0] fault_s = pins_s[2*NUM_MODULES-1:NUM_MODULES];
	wire [NUM_MODULES-1:0] missing_s = pins_s[NUM_MODULES-1:0];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [`IOHSD_CTRL_WIDTH-1:0] ctrl_q;
	reg [`IOHSD_DPV1_WIDTH-1:0] dpv1_q;
	reg [`IOHSD_IRQ_WIDTH-1:0] irq_stat_q;
	reg [`IOHSD_IRQ_WIDTH-1:0] irq_mask_q;
	reg [31:0] rdata_q;
	reg ack_q;

	wire hot_swap = ctrl_q[`IOHSD_CTRL_HOT_SWAP];
	wire start_cons = ctrl_q[`IOHSD_CTRL_START_CONS];
	wire out_dis_en = ctrl_q[`IOHSD_CTRL_OUT_DIS_EN];
	wire diag_stat_en = ctrl_q[`IOHSD_CTRL_DIAG_STAT];
	wire redundant = ctrl_q[`IOHSD_CTRL_REDUNDANT];
	wire dpv1_en = dpv1_q[`IOHSD_DPV1_ENABLE];

	// one wait state per access: answered on the second edge after the request appears;
	// ack_q drops on the answering edge, so a request still held is served
	// again only after another wait state, never twice in one beat
	wire req = (avs_read_in | avs_write_in) & ~ack_q;
	wire wr_take = avs_write_in & ack_q;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_readdata_out = rdata_q;

	// ----------------------------------------
	// policy state machine
	// ----------------------------------------
	// state codes, shared with the status register readout
	localparam [1:0] ST_OFFLINE = `IOHSD_ST_OFFLINE;
	localparam [1:0] ST_STARTUP = `IOHSD_ST_STARTUP;
	localparam [1:0] ST_RUN = `IOHSD_ST_RUN;
	localparam [1:0] ST_ERROR = `IOHSD_ST_ERROR;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg started_q;
	reg online_prev_q;
	reg primary_prev_q;
	reg pwr_prev_q;

	// low-to-high step of a synchronised level against its last value
	function step_up;
		input now_lvl;
		input last_lvl;
		begin
			step_up = now_lvl & ~last_lvl;
		end
	endfunction

	// whether a module fault stops the head: always with hot swap off,
	// only inside start-up when consistency is asked for, never otherwise
	function fault_stops;
		input faulty;
		input swap_on;
		input consistency;
		input starting;
		begin
			if (!swap_on) begin
				fault_stops = faulty; // [R2]
			end else begin
				fault_stops = faulty & consistency & starting; // [R3] [R4] [R7]
			end
		end
	endfunction

	// start-up: first on-line after power, or the primary edge of a redundant pair
	wire online_rise = step_up(online_s, online_prev_q);
	wire primary_rise = step_up(primary_s, primary_prev_q);
	wire startup_evt = pwr_s & ~started_q &
		(redundant ? primary_rise : online_rise); // [R1]
	// a power drop seen at a clock sample rearms start-up; a dip shorter than
	// one clock period can slip between two samples and go unseen
	wire power_drop = step_up(pwr_prev_q, pwr_s); // [R5]

	wire any_fault = (|fault_s) | (|missing_s);
	// changeover is never acted on: started_q stays set, so no second check

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OFFLINE: begin
				if (startup_evt) begin
					state_d = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				// consistency check happens once here, never on changeover
				if (fault_stops(any_fault, hot_swap, start_cons, 1'b1)) begin
					state_d = ST_ERROR; // [R3] [R5]
				end else begin
					state_d = ST_RUN; // [R6]
				end
			end
			ST_RUN: begin
				if (fault_stops(any_fault, hot_swap, start_cons, 1'b0)) begin
					state_d = ST_ERROR; // [R2]
				end
			end
			ST_ERROR: begin
				// left only by the power drop below, which rearms start-up
				state_d = ST_ERROR; // [R16]
			end
			default: begin
				state_d = ST_OFFLINE;
			end
		endcase
		if (power_drop) begin
			state_d = ST_OFFLINE; // [R5] [R16]
		end
	end

	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= `IOHSD_ST_OFFLINE;
			started_q <= 1'b0;
			online_prev_q <= 1'b0;
			primary_prev_q <= 1'b0;
			pwr_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			online_prev_q <= online_s;
			primary_prev_q <= primary_s;
			pwr_prev_q <= pwr_s;
			// only a power drop clears it, so a changeover never rearms the check
			if (power_drop) begin
				started_q <= 1'b0; // [R5]
			end else if (startup_evt) begin
				started_q <= 1'b1; // [R6]
			end
		end
	end

	// ----------------------------------------
	// diagnosis generation
	// ----------------------------------------
	reg [NUM_MODULES-1:0] fault_prev_q;
	reg [NUM_MODULES-1:0] missing_prev_q;
	reg [7:0] sys_prev_q;
	reg diag_q;
	// change against last cycle's copy; changes while off-line are dropped
	wire mod_change = (fault_s != fault_prev_q) | (missing_s != missing_prev_q);
	wire sys_change = (sys_s != sys_prev_q);
	wire diag_d = (state_q != `IOHSD_ST_OFFLINE) &
		(mod_change | (diag_stat_en & sys_change)); // [R9] [R10] [R4] [R7]

	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fault_prev_q <= {NUM_MODULES{1'b0}};
			missing_prev_q <= {NUM_MODULES{1'b0}};
			sys_prev_q <= 8'h00;
			diag_q <= 1'b0;
		end else begin
			fault_prev_q <= fault_s;
			missing_prev_q <= missing_s;
			sys_prev_q <= sys_s;
			diag_q <= diag_d;
		end
	end

	// ----------------------------------------
	// outputs inhibit and acyclic acceptance
	// ----------------------------------------
	reg inhibit_q;
	reg c1_acc_q;
	reg c2_acc_q;
	// inhibit follows the command level, no latching: lifting it frees outputs
	wire inhibit_ok = inhibit_s & out_dis_en; // [R8]
	wire active = (state_q == `IOHSD_ST_RUN);

	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			inhibit_q <= 1'b0;
			c1_acc_q <= 1'b0;
			c2_acc_q <= 1'b0;
		end else begin
			inhibit_q <= inhibit_ok; // [R8]
			// alarm bits of the acyclic config are never consulted
			c1_acc_q <= active & c1_s & dpv1_en; // [R11] [R13]
			c2_acc_q <= active & c2_s; // [R12]
		end
	end

	// outputs stay off through start-up until the consistency check has passed
	assign cyclic_outputs_enable_out = active & ~inhibit_q; // [R16]
	assign outputs_inhibit_out = inhibit_q;
	assign error_state_out = (state_q == `IOHSD_ST_ERROR);
	assign diag_pulse_out = diag_q;
	assign class1_acyc_accept_out = c1_acc_q;
	assign class2_acyc_accept_out = c2_acc_q;

	// ----------------------------------------
	// register file and interrupts
	// ----------------------------------------
	wire [`IOHSD_IRQ_WIDTH-1:0] irq_evt;
	// error entry taken from the next state, so the flag sets on the entering edge
	assign irq_evt[`IOHSD_IRQ_ERROR] = (state_d == `IOHSD_ST_ERROR) & (state_q != `IOHSD_ST_ERROR);
	assign irq_evt[`IOHSD_IRQ_DIAG] = diag_d;
	assign irq_evt[`IOHSD_IRQ_STARTUP] = startup_evt;
	assign irq_evt[`IOHSD_IRQ_INHIBIT] = inhibit_ok & ~inhibit_q;

	wire [`IOHSD_IRQ_WIDTH-1:0] w1c = (wr_take && avs_address_in == `IOHSD_REG_IRQ_STAT) ?
		avs_writedata_in[`IOHSD_IRQ_WIDTH-1:0] : {`IOHSD_IRQ_WIDTH{1'b0}};

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (avs_address_in)
			`IOHSD_REG_CTRL: rd_mux[`IOHSD_CTRL_WIDTH-1:0] = ctrl_q;
			// bit 6 mirrors the changeover level; it is shown, never acted on
			`IOHSD_REG_STATUS: rd_mux[6:0] = {changeover_s, c2_acc_q, inhibit_q, started_q, diag_q, state_q};
			`IOHSD_REG_IRQ_STAT: rd_mux[`IOHSD_IRQ_WIDTH-1:0] = irq_stat_q;
			`IOHSD_REG_IRQ_MASK: rd_mux[`IOHSD_IRQ_WIDTH-1:0] = irq_mask_q;
			`IOHSD_REG_DPV1: rd_mux[`IOHSD_DPV1_WIDTH-1:0] = dpv1_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_q <= `IOHSD_CTRL_RESET;
			dpv1_q <= `IOHSD_DPV1_RESET;
			irq_stat_q <= `IOHSD_IRQ_RESET;
			irq_mask_q <= `IOHSD_IRQ_RESET;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
			if (req & avs_read_in) begin
				rdata_q <= rd_mux;
			end
			// set wins over a simultaneous write-one clear
			irq_stat_q <= (irq_stat_q & ~w1c) | irq_evt;
			if (wr_take) begin
				case (avs_address_in)
					`IOHSD_REG_CTRL: ctrl_q <= avs_writedata_in[`IOHSD_CTRL_WIDTH-1:0];
					`IOHSD_REG_IRQ_MASK: irq_mask_q <= avs_writedata_in[`IOHSD_IRQ_WIDTH-1:0];
					`IOHSD_REG_DPV1: dpv1_q <= avs_writedata_in[`IOHSD_DPV1_WIDTH-1:0];
					default: ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	assign irq_out = |(irq_stat_q & irq_mask_q);
endmodule

/* src/iohsd_sync.v */
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module iohsd_sync #(
	parameter WIDTH = 1
) (
	input wire ref_clk_in,
	input wire rstn_in,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

/* test/iohsd_master_model.sv */
// dp master stand-in raising acyclic requests
`timescale 1ns/1ns
module iohsd_master_model #(
	parameter CHAN_LEN = 244
) (
	input wire ref_clk_in,
	input wire [1:0] want_in,
	output reg class1_acyc_req_out = 1'h0,
	output reg class2_acyc_req_out = 1'h0
);
	// a channel length outside 4..244 bytes is no legal setup: no requests then
	wire chan_ok = (CHAN_LEN >= 4) && (CHAN_LEN <= 244);
	// requests move only just after an edge
	always @(posedge ref_clk_in) begin
		class1_acyc_req_out <= want_in[0] & chan_ok;
		class2_acyc_req_out <= want_in[1] & chan_ok;
	end
endmodule

/* test/iohsd_policy_assertions.sv */
// port checks for the io head policy block
`timescale 1ns/1ns
module iohsd_policy_assertions (
	input wire ref_clk_in,
	input wire rstn_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire avs_waitrequest_out,
	input wire power_good_in,
	input wire class2_acyc_req_in,
	input wire cyclic_outputs_enable_out,
	input wire outputs_inhibit_out,
	input wire error_state_out,
	input wire class2_acyc_accept_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	a_wait_first: assert property ($rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out)
		else $error("no wait on new request");
	a_wait_one: assert property ((avs_read_in | avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("wait too long");
	a_wait_idle: assert property (!(avs_read_in | avs_write_in) |-> !avs_waitrequest_out)
		else $error("wait while idle");
	a_err_blocks: assert property (error_state_out |-> !cyclic_outputs_enable_out)
		else $error("outputs live in error");
	a_err_holds: assert property (error_state_out && power_good_in |=> error_state_out)
		else $error("error left early");
	a_power_loss: assert property (!power_good_in [*4] |=> !error_state_out && !cyclic_outputs_enable_out)
		else $error("state kept over power loss");
	a_inhibit_cuts: assert property (outputs_inhibit_out |-> !cyclic_outputs_enable_out)
		else $error("outputs live while inhibited");
	a_c2_drops: assert property (!class2_acyc_req_in [*4] |=> !class2_acyc_accept_out)
		else $error("accept without request");
endmodule

/* test/iohsd_policy_bench.sv */
// self-checking bench for the io head policy block
`timescale 1ns/1ns
`include "iohsd_defs.vh"
module iohsd_policy_bench;
	reg ref_clk_in = 1'h0, rstn_in = 1'h0, avs_read_in = 1'h0, avs_write_in = 1'h0;
	reg [3:0] avs_address_in = 4'h0;
	reg [31:0] avs_writedata_in = 32'h0, q, seed = 32'hb057312e;
	reg power_good_in = 1'h0, online_in = 1'h0, primary_online_in = 1'h0, inhibit_cmd_in = 1'h0;
	reg redundancy_changeover_request_in = 1'h0;
	reg [7:0] module_fault_in = 8'h0, module_missing_in = 8'h0, system_status_in = 8'h0, r;
	reg [1:0] want = 2'h0;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out, cyclic_outputs_enable_out, outputs_inhibit_out, error_state_out, diag_pulse_out;
	wire class1_acyc_accept_out, class2_acyc_accept_out, irq_out, class1_acyc_req_in, class2_acyc_req_in;
	wire [5:0] pins = {error_state_out, cyclic_outputs_enable_out, outputs_inhibit_out,
		class1_acyc_accept_out, class2_acyc_accept_out, irq_out};
	integer n_mismatch = 0, compares = 0, cyc = 0, n_diag = 0, i, d;
	iohsd_policy i_dut(.*);
	iohsd_master_model i_mst(.ref_clk_in(ref_clk_in), .want_in(want),
		.class1_acyc_req_out(class1_acyc_req_in), .class2_acyc_req_out(class2_acyc_req_in));
	initial forever #25 ref_clk_in = !ref_clk_in;
	// negedge sampling keeps the count clear of edge races
	always @(negedge ref_clk_in) if (diag_pulse_out === 1'h1) n_diag = n_diag + 1;
	always @(posedge ref_clk_in) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			wrap_up;
		end
	end
	task wrap_up;
		begin
			$display("mismatches %0d compares %0d", n_mismatch, compares);
			if (n_mismatch == 0 && compares > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	task chk(input [31:0] nm, input [31:0] e, input [31:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// request held until waitrequest is seen low at an edge
	task bus(input w, input [3:0] a, input [31:0] dat);
		integer n;
		begin
			n = 0;
			avs_address_in <= a;
			avs_write_in <= w;
			avs_read_in <= !w;
			avs_writedata_in <= dat;
			@(posedge ref_clk_in);
			while (avs_waitrequest_out !== 1'h0 && n < 50) begin
				@(posedge ref_clk_in);
				n = n + 1;
			end
			if (n == 50) begin
				n_mismatch = n_mismatch + 1;
				wrap_up;
			end
			q = avs_readdata_out;
			avs_read_in <= 1'h0;
			avs_write_in <= 1'h0;
			@(posedge ref_clk_in);
		end
	endtask
	task rchk(input [3:0] a, input [31:0] e);
		begin
			bus(1'h0, a, 32'h0);
			chk("reg", e, q);
		end
	endtask
	task pchk(input [5:0] e);
		begin
			@(negedge ref_clk_in);
			chk("pins", {26'h0, e}, {26'h0, pins});
			@(posedge ref_clk_in);
		end
	endtask
	// power cycle then come on line with a given setup
	task boot(input [4:0] c, input [7:0] miss, input prim);
		begin
			power_good_in <= 1'h0;
			online_in <= 1'h0;
			primary_online_in <= 1'h0;
			module_missing_in <= miss;
			module_fault_in <= 8'h0;
			wt(6);
			bus(1'h1, `IOHSD_REG_CTRL, {27'h0, c});
			power_good_in <= 1'h1;
			wt(4);
			if (prim) primary_online_in <= 1'h1;
			else online_in <= 1'h1;
			wt(10);
		end
	endtask
	initial begin
		wt(4);
		rstn_in <= 1'h1;
		wt(1);
		bus(1'h1, 4'h9, 32'hffffffff);
		for (i = 0; i < 16; i = i + 1) rchk(i[3:0], 32'h0);
		boot(5'h00, 8'h0, 1'h0);
		pchk(6'h10);
		rchk(`IOHSD_REG_STATUS, 32'ha);
		bus(1'h1, `IOHSD_REG_IRQ_MASK, 32'h1);
		r = 8'h1 << ($random(seed) & 7);
		module_fault_in <= r;
		wt(8);
		pchk(6'h21);
		bus(1'h1, `IOHSD_REG_IRQ_STAT, 32'h1);
		module_fault_in <= 8'h0;
		wt(8);
		pchk(6'h20);
		rchk(`IOHSD_REG_IRQ_STAT, 32'h6);
		bus(1'h1, `IOHSD_REG_IRQ_MASK, 32'h0);
		boot(5'h03, 8'h10, 1'h0);
		pchk(6'h20);
		boot(5'h03, 8'h00, 1'h0);
		d = n_diag;
		module_missing_in <= 8'h04;
		wt(10);
		pchk(6'h10);
		chk("diag", 1, n_diag - d);
		boot(5'h01, 8'hff, 1'h0);
		module_fault_in <= 8'h3c;
		wt(8);
		pchk(6'h10);
		d = n_diag;
		system_status_in <= $random(seed);
		wt(8);
		chk("diag", 0, n_diag - d);
		bus(1'h1, `IOHSD_REG_CTRL, 32'h9);
		d = n_diag;
		system_status_in <= ~system_status_in;
		wt(8);
		chk("diag", 1, n_diag - d);
		inhibit_cmd_in <= 1'h1;
		wt(8);
		pchk(6'h10);
		bus(1'h1, `IOHSD_REG_CTRL, 32'hd);
		wt(8);
		pchk(6'h08);
		inhibit_cmd_in <= 1'h0;
		wt(8);
		pchk(6'h10);
		r = $random(seed);
		bus(1'h1, `IOHSD_REG_DPV1, {24'h0, r[7:1], 1'h0});
		want <= 2'h3;
		wt(8);
		pchk(6'h12);
		bus(1'h1, `IOHSD_REG_DPV1, {24'h0, r[7:1], 1'h1});
		wt(8);
		pchk(6'h16);
		rchk(`IOHSD_REG_DPV1, {24'h0, r[7:1], 1'h1});
		want <= 2'h0;
		wt(8);
		pchk(6'h10);
		boot(5'h13, 8'h0, 1'h1);
		pchk(6'h10);
		redundancy_changeover_request_in <= 1'h1;
		module_fault_in <= 8'h80;
		wt(10);
		pchk(6'h10);
		rchk(`IOHSD_REG_STATUS, 32'h4a);
		wrap_up;
	end
endmodule
bind iohsd_policy iohsd_policy_assertions i_chk(.*);
